// ==== rtl/ddr_refresh_scheduler.sv ====
// Refresh scheduler of the DDR SDRAM controller.
`timescale 1ns/1ns
`default_nettype none
module ddr_refresh_scheduler #(
   parameter int TIMER_W = refresh_pkg::TIMER_W,
   parameter int BANKS   = refresh_pkg::BANKS
) (
   input  wire logic                   mclk,         // Controller clock.
   input  wire logic                   rst_b,        // Asynchronous reset.
   input  wire refresh_pkg::timerCfg_t cfg,          // Timer count and select.
   input  wire logic                   burstActive,  // Burst in progress.
   input  wire logic [BANKS-1:0]       bankOpen,     // Banks currently active.
   input  wire logic                   cmdReady,     // Sequencer took command.
   input  wire logic                   resetCmd,     // RESET command issued.
   input  wire logic                   selfRefExit,  // Self-refresh exited.
   output var  refresh_pkg::refIssue_t issue,        // Command to sequencer.
   output var  logic                   cpuBusy,      // Busy to system bus slave.
   output var  logic [BANKS-1:0]       bankBlocked,  // Banks not accessible.
   output var  logic [BANKS-1:0]       bankIdle      // Banks forced idle.
);

   // ****************************************************************
   // State.
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT_BURST,
      ST_PRECHARGE,
      ST_REFRESH,
      ST_BUSY
   } phase_t;

   typedef struct packed {
      phase_t                              phase;
      logic                                perBank;
      logic [refresh_pkg::BANK_W-1:0]      bank;
      logic [refresh_pkg::CNT_W-1:0]       wait_;
      refresh_pkg::refIssue_t              issue;
      logic                                busy;
      logic [BANKS-1:0]                    blocked;
      logic [BANKS-1:0]                    idle;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic                           pending;
   logic                           taken;
   logic                           advance;
   logic [refresh_pkg::BANK_W-1:0] nextBank;

   initial begin
      if (BANKS != refresh_pkg::BANKS) $error("eight banks required");
      if (refresh_pkg::RFC_AB_CYC >= 2 ** refresh_pkg::CNT_W)
         $error("refresh cycle count too wide");
   end

   refresh_timer #(.TIMER_W(TIMER_W)) uTimer (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .count   (cfg.count),
      .taken   (taken),
      .pending (pending)
   );

   bank_tracker #(.BANK_W(refresh_pkg::BANK_W)) uBanks (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .clear   (resetCmd | selfRefExit),
      .advance (advance),
      .bank    (nextBank)
   );

   // ****************************************************************
   // Sequencing.
   // ****************************************************************
   always_comb begin
      s_d     = s_q;
      taken   = 1'b0;
      advance = 1'b0;
      s_d.idle = '0;
      if (s_q.issue.valid && cmdReady) begin
         s_d.issue.valid = 1'b0;
      end
      unique case (s_q.phase)
         ST_IDLE: begin
            if (pending) begin
               taken       = 1'b1;
               s_d.perBank = cfg.perBankSel;
               s_d.phase   = ST_WAIT_BURST;
            end
         end
         ST_WAIT_BURST: begin
            if (!burstActive) begin
               s_d.busy = 1'b1;
               if (s_q.perBank) begin
                  s_d.bank        = nextBank;
                  s_d.issue.cmd   = refresh_pkg::CMD_REFRESH_BANK;
                  s_d.issue.bank  = nextBank;
                  s_d.issue.valid = 1'b1;
                  s_d.blocked     = '0;
                  s_d.blocked[nextBank] = 1'b1;
                  s_d.phase       = ST_REFRESH;
               end else if (|bankOpen) begin
                  s_d.issue.cmd   = refresh_pkg::CMD_PRECHARGE_ALL;
                  s_d.issue.bank  = '0;
                  s_d.issue.valid = 1'b1;
                  s_d.blocked     = '1;
                  s_d.phase       = ST_PRECHARGE;
               end else begin
                  s_d.issue.cmd   = refresh_pkg::CMD_REFRESH_ALL;
                  s_d.issue.bank  = '0;
                  s_d.issue.valid = 1'b1;
                  s_d.blocked     = '1;
                  s_d.phase       = ST_REFRESH;
               end
            end
         end
         ST_PRECHARGE: begin
            if (s_q.issue.valid && cmdReady) begin
               s_d.issue.cmd   = refresh_pkg::CMD_REFRESH_ALL;
               s_d.issue.valid = 1'b1;
               s_d.phase       = ST_REFRESH;
            end
         end
         ST_REFRESH: begin
            if (s_q.issue.valid && cmdReady) begin
               advance   = s_q.perBank;
               s_d.wait_ = s_q.perBank
                  ? refresh_pkg::CNT_W'(refresh_pkg::RFC_PB_CYC - 1)
                  : refresh_pkg::CNT_W'(refresh_pkg::RFC_AB_CYC - 1);
               s_d.phase = ST_BUSY;
            end
         end
         ST_BUSY: begin
            if (s_q.wait_ == '0) begin
               s_d.busy    = 1'b0;
               s_d.blocked = '0;
               // Every refreshed bank comes back closed.
               if (s_q.perBank) begin
                  s_d.idle[s_q.bank] = 1'b1;
               end else begin
                  s_d.idle = '1;
               end
               s_d.phase = ST_IDLE;
            end else begin
               s_d.wait_ = s_q.wait_ - refresh_pkg::CNT_W'(1);
            end
         end
         default: begin
            s_d.phase = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Internal requesters never look at cpuBusy, so they are not stalled.
   assign issue       = s_q.issue;
   assign cpuBusy     = s_q.busy;
   assign bankBlocked = s_q.blocked;
   assign bankIdle    = s_q.idle;

endmodule : ddr_refresh_scheduler
`default_nettype wire

// ==== rtl/refresh_pkg.sv ====
// Constants and carrier types of the DDR refresh scheduler.
package refresh_pkg;

   // ****************************************************************
   // Sizes and timing.
   // ****************************************************************
   localparam int TIMER_W      = 12;
   localparam int BANKS        = 8;
   localparam int BANK_W       = 3;
   localparam int CLK_MHZ      = 50;
   localparam int RFC_PB_NS    = 90;
   localparam int RFC_AB_NS    = 130;
   localparam int RFC_PB_CYC   = (RFC_PB_NS * CLK_MHZ + 999) / 1000;
   localparam int RFC_AB_CYC   = (RFC_AB_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W        = 8;
   localparam logic [TIMER_W-1:0] TIMER_RST = 12'h000;

   // ****************************************************************
   // Command encoding towards the command sequencer.
   // ****************************************************************
   typedef enum logic [1:0] {
      CMD_NONE,
      CMD_PRECHARGE_ALL,
      CMD_REFRESH_ALL,
      CMD_REFRESH_BANK
   } refCmd_t;

   typedef struct packed {
      logic            valid;
      refCmd_t         cmd;
      logic [BANK_W-1:0] bank;
   } refIssue_t;

   typedef struct packed {
      logic [TIMER_W-1:0] count;
      logic               perBankSel;
   } timerCfg_t;

endpackage : refresh_pkg

// ==== rtl/refresh_timer.sv ====
// Periodic refresh request timer.
`timescale 1ns/1ns
`default_nettype none
module refresh_timer #(
   parameter int TIMER_W = refresh_pkg::TIMER_W
) (
   input  wire logic               mclk,     // Controller clock.
   input  wire logic               rst_b,    // Asynchronous reset.
   input  wire logic [TIMER_W-1:0] count,    // Cycles between refreshes.
   input  wire logic               taken,    // Pending request consumed.
   output var  logic               pending   // Refresh is owed.
);

   typedef struct packed {
      logic [TIMER_W-1:0] cnt;
      logic               pend;
   } state_t;

   state_t s_q;
   state_t s_d;

   initial begin
      if (TIMER_W < 2) $error("refresh_timer: TIMER_W too small");
   end

   always_comb begin
      s_d = s_q;
      if (taken) begin
         s_d.pend = 1'b0;
      end
      if (count == '0) begin
         s_d.cnt = '0;
      end else if (s_q.cnt >= count - TIMER_W'(1)) begin
         s_d.cnt  = '0;
         s_d.pend = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + TIMER_W'(1);
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pending = s_q.pend;

endmodule : refresh_timer
`default_nettype wire

// ==== rtl/bank_tracker.sv ====
// Mirror of the memory's per-bank refresh counter.
`timescale 1ns/1ns
`default_nettype none
module bank_tracker #(
   parameter int BANK_W = refresh_pkg::BANK_W
) (
   input  wire logic              mclk,     // Controller clock.
   input  wire logic              rst_b,    // Asynchronous reset.
   input  wire logic              clear,    // RESET command or self-refresh exit.
   input  wire logic              advance,  // Per-bank refresh issued.
   output var  logic [BANK_W-1:0] bank      // Next bank to refresh.
);

   typedef struct packed {
      logic [BANK_W-1:0] bank;
   } state_t;

   state_t s_q;
   state_t s_d;

   initial begin
      if (BANK_W != 3) $error("bank_tracker: eight banks expected");
   end

   always_comb begin
      s_d = s_q;
      if (clear) begin
         s_d.bank = '0;
      end else if (advance) begin
         s_d.bank = s_q.bank + BANK_W'(1);
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign bank = s_q.bank;

endmodule : bank_tracker
`default_nettype wire

// ==== verif/mem_partner.sv ====
// Memory-side model that accepts commands and mirrors the bank counter.
`timescale 1ns/1ns
`default_nettype none
module mem_partner (
   input  wire logic                   mclk,     // Clock.
   input  wire logic                   rst_b,    // Reset.
   input  wire refresh_pkg::refIssue_t issue,    // Command in.
   input  wire logic                   clrBank,  // RESET or exit.
   input  wire logic                   slow,     // Answer late.
   output var  logic                   cmdReady, // Accepted.
   output var  logic [2:0]             expBank   // Bank counter.
);
   logic [1:0] waitQ;

   // The row address advances inside the memory; none crosses here.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cmdReady <= 1'b0;
         waitQ    <= 2'h0;
         expBank  <= 3'h0;
      end else begin
         cmdReady <= 1'b0;
         if (issue.valid && cmdReady) begin
            waitQ <= 2'h0;
            if (issue.cmd == refresh_pkg::CMD_REFRESH_BANK) begin
               expBank <= expBank + 3'h1;
            end
         end else if (issue.valid) begin
            waitQ    <= waitQ + 2'h1;
            cmdReady <= !slow || waitQ == 2'h2;
         end
         // A clear in the cycle of an accepted bank refresh still wins.
         if (clrBank) begin
            expBank <= 3'h0;
         end
      end
   end
endmodule : mem_partner
`default_nettype wire

// ==== verif/refresh_monitor.sv ====
// Port checker of the refresh scheduler.
`timescale 1ns/1ns
`default_nettype none
module refresh_monitor #(
   parameter int TIMER_W = 12,
   parameter int BANKS   = 8
) (
   input wire logic                   mclk,        // Clock.
   input wire logic                   rst_b,       // Reset.
   input wire refresh_pkg::timerCfg_t cfg,         // Config.
   input wire logic                   burstActive, // Burst.
   input wire logic [BANKS-1:0]       bankOpen,    // Open banks.
   input wire logic                   cmdReady,    // Accept.
   input wire logic                   resetCmd,    // RESET sent.
   input wire logic                   selfRefExit, // Exit.
   input wire refresh_pkg::refIssue_t issue,       // Command.
   input wire logic                   cpuBusy,     // Busy.
   input wire logic [BANKS-1:0]       bankBlocked, // Blocked.
   input wire logic [BANKS-1:0]       bankIdle     // Idle pulse.
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_busy_issue: assert property (
      issue.valid |-> cpuBusy) else $error("busy low with command");
   a_burst_wait: assert property (
      $rose(issue.valid) |-> !$past(burstActive)) else $error("burst cut");
   a_issue_hold: assert property (
      issue.valid && !cmdReady |=> issue.valid && $stable(issue))
      else $error("command dropped");
   a_sel_bank: assert property (
      issue.valid && issue.cmd == refresh_pkg::CMD_REFRESH_BANK
      |-> cfg.perBankSel) else $error("bank refresh when all");
   a_sel_all: assert property (
      issue.valid && issue.cmd == refresh_pkg::CMD_REFRESH_ALL
      |-> !cfg.perBankSel && bankOpen == '0) else $error("bad all refresh");
   a_block_one: assert property (
      issue.valid && issue.cmd == refresh_pkg::CMD_REFRESH_BANK
      |-> $onehot(bankBlocked) && bankBlocked[issue.bank])
      else $error("wrong banks blocked");
   a_block_span: assert property (
      issue.valid && cmdReady && issue.cmd == refresh_pkg::CMD_REFRESH_BANK
      |=> (bankBlocked != '0)[*5] ##1 (bankBlocked == '0 && bankIdle != '0))
      else $error("blocked span wrong");
   a_idle_pulse: assert property (
      bankIdle != '0 |=> bankIdle == '0) else $error("idle not a pulse");
endmodule : refresh_monitor

bind ddr_refresh_scheduler refresh_monitor #(.TIMER_W(TIMER_W),
   .BANKS(BANKS)) mon (.mclk(mclk), .rst_b(rst_b), .cfg(cfg),
   .burstActive(burstActive), .bankOpen(bankOpen), .cmdReady(cmdReady),
   .resetCmd(resetCmd), .selfRefExit(selfRefExit), .issue(issue),
   .cpuBusy(cpuBusy), .bankBlocked(bankBlocked), .bankIdle(bankIdle));
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking testbench of the refresh scheduler.
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic                   mclk;
   logic                   rst_b;
   refresh_pkg::timerCfg_t cfg;
   logic                   burstActive;
   logic [7:0]             bankOpen;
   logic                   cmdReady;
   logic                   resetCmd;
   logic                   selfRefExit;
   logic                   slow;
   logic [2:0]             expBank;
   refresh_pkg::refIssue_t issue;
   logic                   cpuBusy;
   logic [7:0]             bankBlocked;
   logic [7:0]             bankIdle;
   int                     mismatches;
   int                     num_checks;

   ddr_refresh_scheduler dut (.mclk(mclk), .rst_b(rst_b), .cfg(cfg),
      .burstActive(burstActive), .bankOpen(bankOpen), .cmdReady(cmdReady),
      .resetCmd(resetCmd), .selfRefExit(selfRefExit), .issue(issue),
      .cpuBusy(cpuBusy), .bankBlocked(bankBlocked), .bankIdle(bankIdle));
   mem_partner mem (.mclk(mclk), .rst_b(rst_b), .issue(issue),
      .clrBank(resetCmd | selfRefExit), .slow(slow),
      .cmdReady(cmdReady), .expBank(expBank));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test

   // Judges the next command, seen in the cycle in which it is accepted.
   task automatic take(input refresh_pkg::refCmd_t c);
      int n;
      n = 0;
      @(negedge mclk);
      while (!(issue.valid === 1'b1 && cmdReady === 1'b1) && n < 300) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 300) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
      end
      chk(8'(issue.cmd), 8'(c));
      chk(8'(cpuBusy), 8'h01);
      if (c == refresh_pkg::CMD_REFRESH_BANK) begin
         chk(8'(issue.bank), 8'(expBank));
         chk(bankBlocked, 8'h01 << expBank);
      end else begin
         chk(bankBlocked, 8'hFF);
      end
      // The sequencer closes the banks with the precharge it accepts.
      if (c == refresh_pkg::CMD_PRECHARGE_ALL) begin
         bankOpen = 8'h00;
      end
   endtask : take

   task automatic t_banks();
      cfg = '{count: 12'h020, perBankSel: 1'b1};
      for (int i = 0; i < 9; i++) begin
         slow = i[0];
         take(refresh_pkg::CMD_REFRESH_BANK);
      end
   endtask : t_banks

   task automatic t_clear();
      resetCmd = 1'b1;
      @(negedge mclk);
      resetCmd = 1'b0;
      take(refresh_pkg::CMD_REFRESH_BANK);
      take(refresh_pkg::CMD_REFRESH_BANK);
      selfRefExit = 1'b1;
      @(negedge mclk);
      selfRefExit = 1'b0;
      take(refresh_pkg::CMD_REFRESH_BANK);
   endtask : t_clear

   task automatic t_burst();
      burstActive = 1'b1;
      repeat (100) @(negedge mclk);
      chk(8'(issue.valid), 8'h00);
      burstActive = 1'b0;
      take(refresh_pkg::CMD_REFRESH_BANK);
   endtask : t_burst

   task automatic t_all();
      @(negedge mclk);
      cfg.perBankSel = 1'b0;
      bankOpen = 8'h05;
      take(refresh_pkg::CMD_PRECHARGE_ALL);
      take(refresh_pkg::CMD_REFRESH_ALL);
      take(refresh_pkg::CMD_REFRESH_ALL);
   endtask : t_all

   initial begin
      rst_b = 1'b0;
      cfg = '{count: 12'h000, perBankSel: 1'b0};
      burstActive = 1'b0;
      bankOpen = 8'h00;
      resetCmd = 1'b0;
      selfRefExit = 1'b0;
      slow = 1'b0;
      mismatches = 0;
      num_checks = 0;
      repeat (12) @(negedge mclk);
      rst_b = 1'b1;
      t_banks();
      t_clear();
      t_burst();
      t_all();
      stop_test();
   end

   // About fifteen refreshes need under a thousand cycles.
   initial begin
      #200000;
      mismatches++;
      stop_test();
   end
endmodule : tb
`default_nettype wire
